// [dss_defs.svh]
// Constants of the bus service sequencer and byte-lane steering block.
// Assumes inclusion by the package and the design file only.
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH

// Channel numbering; ascending index is also the service order
`define DSS_NUM_CHAN        12
`define DSS_CH_ETH_TX       4'h0
`define DSS_CH_ETH_RX       4'h1
`define DSS_CH_PB_FIRST     4'h2
`define DSS_CH_SCSI_FIRST   4'hA

// Ping-pong halves, in bytes and in 64-bit words
`define DSS_DWORD_BYTES     8
`define DSS_ETH_TX_HALF     80
`define DSS_ETH_RX_HALF     64
`define DSS_TX_HALF_WORDS   4'(`DSS_ETH_TX_HALF / `DSS_DWORD_BYTES)
`define DSS_RX_HALF_WORDS   4'(`DSS_ETH_RX_HALF / `DSS_DWORD_BYTES)

// Page sizes in bytes
`define DSS_PAGE_4K         14'h1000
`define DSS_PAGE_8K         14'h2000

// Descriptor: buffer pointer, byte count, next pointer
`define DSS_DESC_WORDS      2'h3
`define DSS_DESC_BP         2'h0
`define DSS_DESC_BC         2'h1
`define DSS_DESC_DP         2'h2

// Reset values
`define DSS_RST_CHAN        4'h0
`define DSS_RST_PAGE        14'h1000
`endif

// [dss_pkg.sv]
// Types shared by the service sequencer and its bench.
// Assumes dss_defs.svh is on the include path.
package dss_pkg;
    `include "dss_defs.svh"

    typedef logic [3:0] dss_chan_t;

    // What a beat on the data path is, which picks its byte order
    typedef enum logic [1:0] {
        DSS_KIND_DATA = 2'b00,
        DSS_KIND_DESC = 2'b01,
        DSS_KIND_PIO  = 2'b10
    } dss_kind_t;

    // Direction of a transfer
    typedef enum logic {
        DSS_DIR_RX = 1'b0,  // Peripheral to main memory
        DSS_DIR_TX = 1'b1   // Main memory to peripheral
    } dss_dir_t;

    typedef struct packed {
        logic [63:0] data;
        dss_chan_t   chan;
        dss_kind_t   kind;
        dss_dir_t    dir;
    } dss_beat_t;

    typedef enum logic [0:0] {
        DSS_ST_IDLE  = 1'b0,
        DSS_ST_SERVE = 1'b1
    } dss_state_t;
endpackage

// [dss_service_steer.sv]
// Bus tenure service sequencer, ping-pong FIFO halves and byte-lane steering.
// Assumes one synchronous clock domain; all inputs are synchronous to clk_sys.
// How it works
// - On each bus grant the Ethernet channels are served first, then the peripheral-bus DMA channels, then the two SCSI channels.
// - The peripheral side of a FIFO keeps its own RAM port and address, so it runs on while the bus side fills or drains.
// - The Ethernet transmit RAM runs as two 80-byte halves and the receive RAM as two 64-byte halves, alternating.
// - Each DMA channel picks its byte order from its own configuration bit, so channels may differ at once.
// - The channel byte order applies to every data beat of that channel, in both directions between FIFO and bus.
// - All descriptor words are steered by one global byte order bit, whatever the channel settings.
// - Programmed I/O takes its byte order from the endian bit driven during the byte-count cycle.
// - In big endian, byte 0 lies on bits 63:56 down to byte 7 on bits 7:0.
// - In little endian, byte 0 lies on bits 7:0 up to byte 7 on bits 63:56.
// - Bit 0 is always least significant and bit fields never move with byte order.
// - Signals ending in _n are active low and all others active high.
// - The page limit is the smaller of the physical page and the memory page, each 4k or 8k.
// - A receive moves data from the peripheral to memory and a transmit from memory to the peripheral.
// - A descriptor is three 32-bit words: buffer pointer, byte count, next pointer.
module dss_service_steer
(
    // Clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // Bus tenure and service handshake
    input  wire logic                              grant_n,
    input  wire logic [`DSS_NUM_CHAN-1:0]          svc_req,
    input  wire logic                              svc_ack,
    output logic                                   svc_vld_r,
    output dss_pkg::dss_chan_t                     svc_chan_r,
    output logic                                   tenure_end_r,
    // Byte order configuration
    input  wire logic [`DSS_NUM_CHAN-1:0]          chan_big,
    input  wire logic                              desc_big,
    input  wire logic                              bc_cycle,
    input  wire logic                              bc_endian_big,
    // Data path, canonical side in
    input  wire logic                              in_vld,
    input  dss_pkg::dss_beat_t                     in_beat,
    output logic                                   in_rdy_r,
    // Data path, steered side out
    output logic                                   out_vld_r,
    output dss_pkg::dss_beat_t                     out_beat_r,
    input  wire logic                              out_rdy,
    // Descriptor words
    input  wire logic                              desc_vld,
    input  wire logic [31:0]                       desc_data,
    output logic [31:0]                            desc_bp_r,
    output logic [31:0]                            desc_bc_r,
    output logic [31:0]                            desc_dp_r,
    output logic                                   desc_done_r,
    // Ethernet ping-pong rings: index 0 transmit, 1 receive
    input  wire logic [1:0]                        ring_fill,
    input  wire logic [1:0]                        ring_drain,
    output logic [1:0]                             ring_fill_rdy_r,
    output logic [1:0]                             ring_drain_rdy_r,
    output logic [1:0][4:0]                        ring_fill_addr_r,
    output logic [1:0][4:0]                        ring_drain_addr_r,
    // Page sizing
    input  wire logic                              page_phys_8k,
    input  wire logic                              page_mem_8k,
    output logic [13:0]                            page_bytes_r
);
    import dss_pkg::*;

    typedef struct packed {
        dss_state_t                    st;
        logic [`DSS_NUM_CHAN-1:0]      left;
        logic                          svc_vld;
        dss_chan_t                     svc_chan;
        logic                          tenure_end;
        logic                          pio_big;
        logic                          grant_seen;
        logic [1:0][$bits(dss_beat_t)-1:0] buf_q;
        logic [1:0]                    cnt;
        logic                          in_rdy;
        logic                          out_vld;
        logic [1:0]                    desc_idx;
        logic [31:0]                   bp;
        logic [31:0]                   bc;
        logic [31:0]                   dp;
        logic                          desc_done;
        logic [1:0]                    fill_half;
        logic [1:0][3:0]               fill_cnt;
        logic [1:0]                    drain_half;
        logic [1:0][3:0]               drain_cnt;
        logic [1:0][1:0]               full;
        logic [1:0]                    fill_rdy;
        logic [1:0]                    drain_rdy;
        logic [1:0][4:0]               fill_addr;
        logic [1:0][4:0]               drain_addr;
        logic [13:0]                   page;
    } dss_regs_t;

    dss_regs_t r;
    dss_regs_t nxt;

    // Byte reversal: bit numbering never changes, only which lane a byte index sits on
    function automatic logic [63:0] swap64(input logic [63:0] d);
        logic [63:0] s;
        s = '0;
        for (int i = 0; i < 8; i++)
        begin
            s[8*i +: 8] = d[8*(7-i) +: 8];
        end
        return s;
    endfunction

    function automatic logic [31:0] swap32(input logic [31:0] d);
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    // Lowest pending channel; lowest index is the highest service priority
    function automatic dss_chan_t first_set(input logic [`DSS_NUM_CHAN-1:0] m);
        dss_chan_t c;
        c = `DSS_RST_CHAN;
        for (int i = `DSS_NUM_CHAN - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                c = 4'(i);
            end
        end
        return c;
    endfunction

    function automatic logic [3:0] half_words(input int ring);
        return (ring == 0) ? `DSS_TX_HALF_WORDS : `DSS_RX_HALF_WORDS;
    endfunction

    function automatic logic [4:0] ring_addr(input int ring, input logic half,
                                             input logic [3:0] cnt);
        return (half ? 5'(half_words(ring)) : 5'h00) + 5'(cnt);
    endfunction

    // Next state of every register of the block
    always_comb
    begin
        dss_beat_t        b;
        logic             big;
        logic             push;
        logic             pop;
        logic [31:0]      w;
        logic [1:0]       set_full;
        logic [1:0]       clr_full;
        b        = in_beat;
        big      = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        w        = '0;
        set_full = '0;
        clr_full = '0;
        nxt      = r;
        nxt.tenure_end = 1'b0;
        nxt.desc_done  = 1'b0;

        // Tenure sequencer; the grant strobe is low true and edge detected
        nxt.grant_seen = ~grant_n;
        case (r.st)
            DSS_ST_IDLE:
            begin
                if (!grant_n && !r.grant_seen)
                begin
                    if (svc_req != '0)
                    begin
                        nxt.st       = DSS_ST_SERVE;
                        nxt.left     = svc_req;
                        nxt.svc_vld  = 1'b1;
                        nxt.svc_chan = first_set(svc_req);
                    end
                    else
                    begin
                        nxt.tenure_end = 1'b1;
                    end
                end
            end
            DSS_ST_SERVE:
            begin
                if (svc_ack)
                begin
                    // Requests that arrive mid-tenure wait for the next grant
                    nxt.left = r.left & ~(`DSS_NUM_CHAN'(1) << r.svc_chan);
                    if (nxt.left == '0)
                    begin
                        nxt.st         = DSS_ST_IDLE;
                        nxt.svc_vld    = 1'b0;
                        nxt.tenure_end = 1'b1;
                    end
                    else
                    begin
                        nxt.svc_chan = first_set(nxt.left);
                    end
                end
            end
            default:
            begin
                nxt.st      = DSS_ST_IDLE;
                nxt.svc_vld = 1'b0;
            end
        endcase

        // Programmed I/O order is caught in the byte-count cycle and kept
        if (bc_cycle)
        begin
            nxt.pio_big = bc_endian_big;
        end

        // Steering on entry; a swap is its own inverse, so one path serves both directions
        case (in_beat.kind)
            DSS_KIND_DATA: big = chan_big[in_beat.chan];
            DSS_KIND_DESC: big = desc_big;
            DSS_KIND_PIO:  big = nxt.pio_big;
            default:       big = 1'b0;
        endcase
        b.data = big ? swap64(in_beat.data) : in_beat.data;

        // Two-entry buffer; a receiver stall loses no word
        push = in_vld && r.in_rdy;
        pop  = r.out_vld && out_rdy;
        if (pop)
        begin
            nxt.buf_q[0] = r.buf_q[1];
        end
        if (push)
        begin
            nxt.buf_q[(r.cnt - 2'(pop)) == 2'h0 ? 0 : 1] = b;
        end
        nxt.cnt     = r.cnt + 2'(push) - 2'(pop);
        nxt.in_rdy  = nxt.cnt != 2'h2;
        nxt.out_vld = nxt.cnt != 2'h0;

        // Descriptor assembly, words in pointer, count, next order
        if (desc_vld)
        begin
            w = desc_big ? swap32(desc_data) : desc_data;
            case (r.desc_idx)
                `DSS_DESC_BP: nxt.bp = w;
                `DSS_DESC_BC: nxt.bc = w;
                `DSS_DESC_DP: nxt.dp = w;
                default:      nxt.bp = w;
            endcase
            if (r.desc_idx == `DSS_DESC_WORDS - 2'h1)
            begin
                nxt.desc_idx  = 2'h0;
                nxt.desc_done = 1'b1;
            end
            else
            begin
                nxt.desc_idx = r.desc_idx + 2'h1;
            end
        end

        // Ping-pong halves; fill and drain own separate RAM ports and counters
        for (int i = 0; i < 2; i++)
        begin
            set_full = '0;
            clr_full = '0;
            if (ring_fill[i] && r.fill_rdy[i])
            begin
                if (r.fill_cnt[i] == half_words(i) - 4'h1)
                begin
                    set_full[r.fill_half[i]] = 1'b1;
                    nxt.fill_half[i]         = ~r.fill_half[i];
                    nxt.fill_cnt[i]          = 4'h0;
                end
                else
                begin
                    nxt.fill_cnt[i] = r.fill_cnt[i] + 4'h1;
                end
            end
            if (ring_drain[i] && r.drain_rdy[i])
            begin
                if (r.drain_cnt[i] == half_words(i) - 4'h1)
                begin
                    clr_full[r.drain_half[i]] = 1'b1;
                    nxt.drain_half[i]         = ~r.drain_half[i];
                    nxt.drain_cnt[i]          = 4'h0;
                end
                else
                begin
                    nxt.drain_cnt[i] = r.drain_cnt[i] + 4'h1;
                end
            end
            // Set wins over clear should both hit one half
            nxt.full[i]       = (r.full[i] & ~clr_full) | set_full;
            nxt.fill_rdy[i]   = ~nxt.full[i][nxt.fill_half[i]];
            nxt.drain_rdy[i]  = nxt.full[i][nxt.drain_half[i]];
            nxt.fill_addr[i]  = ring_addr(i, nxt.fill_half[i], nxt.fill_cnt[i]);
            nxt.drain_addr[i] = ring_addr(i, nxt.drain_half[i], nxt.drain_cnt[i]);
        end

        // Page limit is the smaller of the two page sizes
        nxt.page = (page_phys_8k && page_mem_8k) ? `DSS_PAGE_8K : `DSS_PAGE_4K;
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            r           <= '0;
            r.st        <= DSS_ST_IDLE;
            r.svc_chan  <= `DSS_RST_CHAN;
            r.grant_seen <= 1'b1;    // A grant held through reset is not a new tenure
            r.in_rdy    <= 1'b1;
            r.fill_rdy  <= 2'b11;
            r.page      <= `DSS_RST_PAGE;
        end
        else
        begin
            r <= nxt;
        end
    end

    // Outputs straight from the state register
    assign svc_vld_r         = r.svc_vld;
    assign svc_chan_r        = r.svc_chan;
    assign tenure_end_r      = r.tenure_end;
    assign in_rdy_r          = r.in_rdy;
    assign out_vld_r         = r.out_vld;
    assign out_beat_r        = dss_beat_t'(r.buf_q[0]);
    assign desc_bp_r         = r.bp;
    assign desc_bc_r         = r.bc;
    assign desc_dp_r         = r.dp;
    assign desc_done_r       = r.desc_done;
    assign ring_fill_rdy_r   = r.fill_rdy;
    assign ring_drain_rdy_r  = r.drain_rdy;
    assign ring_fill_addr_r  = r.fill_addr;
    assign ring_drain_addr_r = r.drain_addr;
    assign page_bytes_r      = r.page;
endmodule

// [dss_props.sv]
// Checker of service order, lane steering, rings and page size.
// Bound to dss_service_steer; it sees the ports of that module only.
module dss_props
(
    // Clock and reset
    input wire logic            clk_sys,
    input wire logic            rst,
    // Service
    input wire logic            grant_n,
    input wire logic [11:0]     svc_req,
    input wire logic            svc_ack,
    input wire logic            svc_vld_r,
    input dss_pkg::dss_chan_t   svc_chan_r,
    input wire logic            tenure_end_r,
    // Steering
    input wire logic [11:0]     chan_big,
    input wire logic            desc_big,
    input wire logic            bc_cycle,
    input wire logic            bc_endian_big,
    input wire logic            in_vld,
    input dss_pkg::dss_beat_t   in_beat,
    input wire logic            in_rdy_r,
    input wire logic            out_vld_r,
    input dss_pkg::dss_beat_t   out_beat_r,
    input wire logic            desc_vld,
    input wire logic [31:0]     desc_data,
    input wire logic [31:0]     desc_dp_r,
    input wire logic            desc_done_r,
    // Rings and page
    input wire logic [1:0]      ring_fill,
    input wire logic [1:0]      ring_fill_rdy_r,
    input wire logic [1:0][4:0] ring_fill_addr_r,
    input wire logic [1:0]      ring_drain,
    input wire logic [1:0]      ring_drain_rdy_r,
    input wire logic [1:0][4:0] ring_drain_addr_r,
    input wire logic            page_phys_8k,
    input wire logic            page_mem_8k,
    input wire logic [13:0]     page_bytes_r
);
    import dss_pkg::*;
    logic        pio_big_r;
    logic [1:0]  dcnt_r;
    logic        big_w;
    logic [63:0] exp_w;
    logic [31:0] dexp_w;

    // Lowest pending channel index
    function automatic logic [3:0] low_idx(input logic [11:0] r);
        low_idx = 4'h0;
        for (int i = 11; i >= 0; i--)
            if (r[i])
                low_idx = 4'(i);
    endfunction

    // Expected values; a byte-count cycle in the same beat already counts
    always_comb
    begin
        case (in_beat.kind)
            DSS_KIND_DESC: big_w = desc_big;
            DSS_KIND_PIO:  big_w = bc_cycle ? bc_endian_big : pio_big_r;
            default:       big_w = chan_big[in_beat.chan];
        endcase
        exp_w = in_beat.data;
        if (big_w)
            exp_w = {<<8{in_beat.data}};
        dexp_w = desc_data;
        if (desc_big)
            dexp_w = {<<8{desc_data}};
    end

    // Held endian bit of the last byte-count cycle, and descriptor word count
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pio_big_r <= 1'b0;
            dcnt_r    <= 2'h0;
        end
        else
        begin
            if (bc_cycle)
                pio_big_r <= bc_endian_big;
            if (desc_vld)
                dcnt_r <= (dcnt_r == 2'h2) ? 2'h0 : dcnt_r + 2'h1;
        end
    end

    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Only beats entering an empty buffer are tied to the next output
    chk_grant_lowest: assert property (
        $fell(grant_n) && !svc_vld_r && !tenure_end_r && svc_req != '0
        |=> svc_vld_r && svc_chan_r == low_idx($past(svc_req)))
        else $error("not the lowest channel");
    chk_grant_empty: assert property (
        $fell(grant_n) && !svc_vld_r && !tenure_end_r && svc_req == '0
        |=> tenure_end_r && !svc_vld_r)
        else $error("empty grant not ended");
    chk_ack_ascends: assert property (
        svc_vld_r && svc_ack
        |=> (!svc_vld_r && tenure_end_r) || (svc_vld_r && svc_chan_r > $past(svc_chan_r)))
        else $error("order not ascending");
    chk_beat_lanes: assert property (
        in_vld && in_rdy_r && !out_vld_r |=> out_vld_r && out_beat_r.data == $past(exp_w))
        else $error("wrong lanes");
    chk_desc_third: assert property (
        desc_vld && dcnt_r == 2'h2 |=> desc_done_r && desc_dp_r == $past(dexp_w))
        else $error("wrong next pointer");
    chk_page_min: assert property (
        1'b1 |=> page_bytes_r == ($past(page_phys_8k && page_mem_8k) ? 14'h2000 : 14'h1000))
        else $error("wrong page size");
    chk_tx_fill_wrap: assert property (
        ring_fill[0] && ring_fill_rdy_r[0]
        |=> ring_fill_addr_r[0] == ($past(ring_fill_addr_r[0]) + 5'h01) % 5'h14)
        else $error("tx fill address");
    chk_rx_drain_wrap: assert property (
        ring_drain[1] && ring_drain_rdy_r[1]
        |=> ring_drain_addr_r[1] == ($past(ring_drain_addr_r[1]) + 5'h01) % 5'h10)
        else $error("rx drain address");
endmodule

bind dss_service_steer dss_props props_u (.*);

// [dss_bus_model.sv]
// Bus master model: grants the bus, acknowledges served channels, stalls output.
// Assumes the bench raises go for one edge to ask for a tenure.
module dss_bus_model
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Bench control
    input  wire logic       go,
    input  wire logic [3:0] ack_wait,
    input  wire logic       stall,
    // Block side
    input  wire logic       svc_vld_r,
    input  wire logic       tenure_end_r,
    output logic            grant_n,
    output logic            svc_ack,
    output logic            out_rdy
);
    logic [3:0] wait_r;

    // Output is taken unless the bench stalls the master
    assign out_rdy = !stall;

    // Grant held low until the tenure ends; ack waits so slow masters are seen
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            grant_n <= 1'b1;
            svc_ack <= 1'b0;
            wait_r  <= 4'h0;
        end
        else
        begin
            if (go)
                grant_n <= 1'b0;
            else if (tenure_end_r)
                grant_n <= 1'b1;
            svc_ack <= 1'b0;
            if (svc_vld_r && !svc_ack)
            begin
                wait_r <= wait_r + 4'h1;
                if (wait_r == ack_wait)
                begin
                    svc_ack <= 1'b1;
                    wait_r  <= 4'h0;
                end
            end
        end
    end
endmodule

// [dss_service_steer_tb_top.sv]
// Self-checking bench for the service sequencer and byte-lane steering block.
// Assumes dss_pkg, the bus model and the bound checker are compiled first.
module dss_service_steer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dss_pkg::*;

    localparam logic [63:0] pat = 64'h0011_2233_4455_6677;
    logic            clk_sys, rst, grant_n, svc_ack, svc_vld_r, tenure_end_r, go, stall;
    logic            desc_big, bc_cycle, bc_endian_big, in_vld, in_rdy_r, out_vld_r, out_rdy;
    logic            desc_vld, desc_done_r, page_phys_8k, page_mem_8k;
    logic [11:0]     svc_req, chan_big;
    logic [3:0]      ack_wait;
    dss_chan_t       svc_chan_r;
    dss_beat_t       in_beat, out_beat_r;
    logic [31:0]     desc_data, desc_bp_r, desc_bc_r, desc_dp_r;
    logic [1:0]      ring_fill, ring_drain, ring_fill_rdy_r, ring_drain_rdy_r;
    logic [1:0][4:0] ring_fill_addr_r, ring_drain_addr_r;
    logic [13:0]     page_bytes_r;
    int              miscompares, checks;

    // Block under test and the bus master facing it
    dss_service_steer dut_u
    (
        .*
    );
    dss_bus_model bus_u
    (
        .*
    );

    // 50 ns clock
    always #25 clk_sys = ~clk_sys;

    function automatic logic [63:0] swap(input logic [63:0] d);
        swap = {<<8{d}};
    endfunction

    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Bounded wait: 0 input ready, 1 output taken
    task automatic await(input int sel);
        int n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (!(sel == 0 ? in_rdy_r : out_vld_r && out_rdy) && n < 200);
        if (n >= 200)
        begin
            miscompares++;
            $display("mismatch handshake expected done seen timeout");
            wrap_up();
        end
    endtask

    // One tenure; requests changed mid-tenure must be ignored
    task automatic run_tenure(input logic [11:0] req, input logic [3:0] aw);
        logic [3:0] exp_q[$];
        int n = 0;
        for (int i = 0; i < 12; i++)
            if (req[i])
                exp_q.push_back(4'(i));
        svc_req  <= req;
        ack_wait <= aw;
        go       <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        svc_req <= 12'hFFF;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (svc_vld_r && svc_ack)
                cmp("served channel", exp_q.pop_front(), svc_chan_r);
        end
        while (!tenure_end_r && n < 200);
        cmp("channels left", 0, exp_q.size());
        cmp("tenure ended", 1, tenure_end_r);
        if (n >= 200)
            wrap_up();
        $display("test tenure done");
    endtask

    task automatic pass_beat(input dss_beat_t b, input logic big);
        in_beat <= b;
        in_vld  <= 1'b1;
        await(0);
        in_vld <= 1'b0;
        await(1);
        cmp("steered data", big ? swap(b.data) : b.data, out_beat_r.data);
        cmp("beat fields", {b.chan, b.kind, b.dir}, out_beat_r[6:0]);
    endtask

    // Opposite SCSI orders, then descriptor and PIO beats
    task automatic t_lanes();
        chan_big      <= 12'h800;
        desc_big      <= 1'b1;
        bc_cycle      <= 1'b1;
        bc_endian_big <= 1'b1;
        @(posedge clk_sys);
        bc_cycle      <= 1'b0;
        bc_endian_big <= 1'b0;
        pass_beat('{pat, 4'hA, DSS_KIND_DATA, DSS_DIR_RX}, 1'b0);
        pass_beat('{pat, 4'hB, DSS_KIND_DATA, DSS_DIR_TX}, 1'b1);
        pass_beat('{pat, 4'h3, DSS_KIND_DESC, DSS_DIR_TX}, 1'b1);
        pass_beat('{pat, 4'h0, DSS_KIND_PIO, DSS_DIR_RX}, 1'b1);
        desc_big <= 1'b0;
        pass_beat('{pat, 4'hB, DSS_KIND_DESC, DSS_DIR_RX}, 1'b0);
        $display("test lanes done");
    endtask

    // Fill the buffer while stalled, then drain it
    task automatic t_buffer();
        int n = 0;
        stall   <= 1'b1;
        in_beat <= '{pat, 4'hA, DSS_KIND_DATA, DSS_DIR_RX};
        in_vld  <= 1'b1;
        repeat (5)
        begin
            @(posedge clk_sys);
            if (in_rdy_r)
            begin
                n++;
                in_beat.data <= ~pat;
            end
        end
        in_vld <= 1'b0;
        stall  <= 1'b0;
        cmp("words taken", 2, n);
        await(1);
        cmp("first drained", pat, out_beat_r.data);
        await(1);
        cmp("second drained", ~pat, out_beat_r.data);
        @(posedge clk_sys);
        cmp("buffer empty", 0, out_vld_r);
        $display("test buffer done");
    endtask

    task automatic t_desc(input logic big);
        logic [31:0] w[3] = '{32'h1122_3344, 32'h8000_0040, 32'hA0B0_C0D0};
        logic [31:0] got[3];
        desc_big <= big;
        desc_vld <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            desc_data <= w[i];
            @(posedge clk_sys);
        end
        desc_vld <= 1'b0;
        @(posedge clk_sys);
        got = '{desc_bp_r, desc_bc_r, desc_dp_r};
        cmp("descriptor done", 1, desc_done_r);
        for (int i = 0; i < 3; i++)
            cmp("descriptor word", big ? swap({w[i], 32'h0}) : 64'(w[i]), got[i]);
        $display("test descriptor done");
    endtask

    // Fill both rings, then drain while filling on
    task automatic t_rings();
        ring_fill <= 2'b11;
        repeat (8) @(posedge clk_sys);
        ring_fill <= 2'b01;
        repeat (2) @(posedge clk_sys);
        ring_fill <= 2'b00;
        @(posedge clk_sys);
        cmp("fill addresses", {5'h08, 5'h0A}, ring_fill_addr_r);
        cmp("drain ready", 2'b11, ring_drain_rdy_r);
        cmp("fill ready", 2'b11, ring_fill_rdy_r);
        ring_fill  <= 2'b11;
        ring_drain <= 2'b11;
        repeat (8) @(posedge clk_sys);
        ring_fill  <= 2'b00;
        ring_drain <= 2'b00;
        @(posedge clk_sys);
        cmp("drain addresses", {5'h08, 5'h08}, ring_drain_addr_r);
        cmp("fill after drain", {5'h00, 5'h12}, ring_fill_addr_r);
        $display("test rings done");
    endtask

    task automatic t_page();
        for (int i = 0; i < 4; i++)
        begin
            {page_phys_8k, page_mem_8k} <= 2'(i);
            repeat (2) @(posedge clk_sys);
            cmp("page size", (i == 3) ? 14'h2000 : 14'h1000, page_bytes_r);
        end
        $display("test page done");
    endtask

    // Reset for six cycles, then each scenario in turn
    initial
    begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {go, stall, desc_big, bc_cycle, bc_endian_big, in_vld, desc_vld} = '0;
        {page_phys_8k, page_mem_8k, ring_fill, ring_drain, svc_req, chan_big, ack_wait} = '0;
        {desc_data, in_beat} = '0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        run_tenure(12'hC85, 4'h2);
        run_tenure(12'h000, 4'h0);
        run_tenure(12'hFFF, 4'h0);
        t_lanes();
        t_buffer();
        t_desc(1'b1);
        t_desc(1'b0);
        t_rings();
        t_page();
        wrap_up();
    end
endmodule
